//--- rtl/sbs_sram_control.v
// Purpose: control logic of a pipelined-address burst static memory
// Assumes: pins already synchronous to clock; array held in flip-flops
// Notes: read words are also copied into a 4-word FIFO for a local tap
`timescale 1ns/1ps
`include "sbs_regs.vh"
module sbs_sram_control
(
   // clock and reset
   input wire clock,
   input wire arst_n,
   // control pins
   input wire clockGate_n,
   input wire advanceOrLoad,
   input wire readNotWrite,
   input wire chipSelectLowA_n,
   input wire chipSelectLowB_n,
   input wire chipSelectHigh,
   input wire outputEnable_n,
   input wire burstOrderSelect,
   input wire [3:0] byteLaneWrite_n,
   input wire [16:0] wordAddress,
   // data pins, split into in, out and enable
   input wire [31:0] dataIn,
   input wire [3:0] parityLanesIn,
   output wire [31:0] dataOut,
   output wire [3:0] parityLanesOut,
   output wire dataOe,
   // read word tap with back-pressure
   output wire tapValid,
   input wire tapReady,
   output wire [35:0] tapData,
   output wire tapOverflow
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_READ = 3'b010;
   localparam [2:0] ST_WRITE = 3'b100;

   // synchronisers for pins
   reg [1:0] gateSync_q;
   reg [1:0] advSync_q;
   reg [1:0] rwSync_q;
   reg [1:0] selASync_q;
   reg [1:0] selBSync_q;
   reg [1:0] selHSync_q;
   reg [1:0] orderSync_q;
   reg [3:0] laneSync1_q;
   reg [3:0] laneSync2_q;
   reg [16:0] addrSync1_q;
   reg [16:0] addrSync2_q;
   reg [35:0] dinSync1_q;
   reg [35:0] dinSync2_q;

   // pipeline state
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [16:0] baseAddr_q;
   reg [1:0] count_q;
   reg [1:0] count_d;
   reg [16:0] accAddr_q;
   reg [16:0] accAddr_d;
   reg [3:0] lanes_q;
   reg [3:0] lanes_d;
   reg xferRead_q;
   reg xferRead_d;
   reg xferWrite_q;
   reg xferWrite_d;
   reg [35:0] rdWord_q;
   reg drive_q;
   reg ovf_q;
   reg [35:0] mem [0:`SBS_DEPTH-1];

   wire run;
   wire adv;
   wire selected;
   wire load;
   wire fifoInReady;
   wire [35:0] wrWord;
   wire [35:0] rdNow;

   // next low address bits for a given start and count
   function [1:0] burstLow;
      input [1:0] start;
      input [1:0] cnt;
      input interleave;
      begin
         if (interleave)
            burstLow = start ^ cnt;
         else
            burstLow = start + cnt;
      end
   endfunction

   // merge new lanes into an old word
   function [35:0] laneMerge;
      input [35:0] oldWord;
      input [35:0] newWord;
      input [3:0] en_n;
      integer j;
      begin
         laneMerge = oldWord;
         for (j = 0; j < 4; j = j + 1)
            if (!en_n[j])
            begin
               laneMerge[j*8 +: 8] = newWord[j*8 +: 8];
               laneMerge[32+j] = newWord[32+j];
            end
      end
   endfunction

   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         gateSync_q <= 2'b11;
         advSync_q <= 2'b00;
         rwSync_q <= 2'b11;
         selASync_q <= 2'b11;
         selBSync_q <= 2'b11;
         selHSync_q <= 2'b00;
         orderSync_q <= 2'b00;
         laneSync1_q <= 4'hF;
         laneSync2_q <= 4'hF;
         addrSync1_q <= 17'h0_0000;
         addrSync2_q <= 17'h0_0000;
         dinSync1_q <= 36'h0_0000_0000;
         dinSync2_q <= 36'h0_0000_0000;
      end
      else
      begin
         gateSync_q <= {gateSync_q[0], clockGate_n};
         advSync_q <= {advSync_q[0], advanceOrLoad};
         rwSync_q <= {rwSync_q[0], readNotWrite};
         selASync_q <= {selASync_q[0], chipSelectLowA_n};
         selBSync_q <= {selBSync_q[0], chipSelectLowB_n};
         selHSync_q <= {selHSync_q[0], chipSelectHigh};
         orderSync_q <= {orderSync_q[0], burstOrderSelect};
         laneSync1_q <= byteLaneWrite_n;
         laneSync2_q <= laneSync1_q;
         addrSync1_q <= wordAddress;
         addrSync2_q <= addrSync1_q;
         dinSync1_q <= {parityLanesIn, dataIn};
         dinSync2_q <= dinSync1_q;
      end
   end

   assign run = !gateSync_q[1];
   assign adv = advSync_q[1];
   assign selected = !selASync_q[1] && !selBSync_q[1]
      && selHSync_q[1];
   assign load = !adv && selected;
   // write data is the registered pin word of the data cycle
   assign wrWord = dinSync2_q;

   // next state of the address and control pipeline
   always @*
   begin
      state_d = state_q;
      count_d = count_q;
      accAddr_d = accAddr_q;
      lanes_d = laneSync2_q;
      xferRead_d = 1'b0;
      xferWrite_d = 1'b0;
      if (!adv)
      begin
         if (selected)
         begin
            // load: external address, direction latched here
            count_d = 2'b00;
            accAddr_d = addrSync2_q;
            if (rwSync_q[1])
            begin
               state_d = ST_READ;
               xferRead_d = 1'b1;
            end
            else
            begin
               state_d = ST_WRITE;
               xferWrite_d = 1'b1;
            end
         end
         else
            state_d = ST_IDLE;
      end
      else
      begin
         case (state_q)
            ST_READ:
            begin
               count_d = count_q + 2'b01;
               accAddr_d = {baseAddr_q[16:2],
                  burstLow(baseAddr_q[1:0], count_d,
                  orderSync_q[1])};
               xferRead_d = 1'b1;
            end
            ST_WRITE:
            begin
               count_d = count_q + 2'b01;
               accAddr_d = {baseAddr_q[16:2],
                  burstLow(baseAddr_q[1:0], count_d,
                  orderSync_q[1])};
               xferWrite_d = 1'b1;
            end
            ST_IDLE:
               state_d = ST_IDLE; // no-op after deselect
            default:
               state_d = ST_IDLE;
         endcase
      end
   end

   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= ST_IDLE;
         baseAddr_q <= 17'h0_0000;
         count_q <= 2'b00;
         accAddr_q <= 17'h0_0000;
         lanes_q <= 4'hF;
         xferRead_q <= 1'b0;
         xferWrite_q <= 1'b0;
         drive_q <= 1'b0;
      end
      else if (run)
      begin
         state_q <= state_d;
         count_q <= count_d;
         accAddr_q <= accAddr_d;
         lanes_q <= lanes_d;
         xferRead_q <= xferRead_d;
         xferWrite_q <= xferWrite_d;
         // floats one cycle after deselect or a write load
         drive_q <= xferRead_d;
         if (load)
            baseAddr_q <= addrSync2_q;
      end
   end

   // array write in the data cycle; finishes even under deselect
   always @(posedge clock)
   begin
      if (run && xferWrite_q)
         mem[accAddr_q] <= laneMerge(mem[accAddr_q], wrWord,
            lanes_q);
   end

   // flow-through read path, lane enables play no part
   assign rdNow = mem[accAddr_q];

   // pins hold their word while suspended
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         rdWord_q <= 36'h0_0000_0000;
      else if (run && xferRead_d)
         rdWord_q <= mem[accAddr_d];
   end

   assign dataOut = rdWord_q[31:0];
   assign parityLanesOut = rdWord_q[35:32];
   assign dataOe = drive_q && xferRead_q && !outputEnable_n;

   // read tap: one entry per completed read word, none while the tap is full
   sbs_fifo #(
      .WIDTH(`SBS_DATA_W),
      .DEPTH(`SBS_FIFO_DEPTH),
      .AW(`SBS_FIFO_AW)
   ) tapFifo (
      .clock(clock),
      .arst_n(arst_n),
      .inValid(run && xferRead_q),
      .inReady(fifoInReady),
      .inData(rdNow),
      .outValid(tapValid),
      .outReady(tapReady),
      .outData(tapData)
   );

   // the memory cannot stall, so a full tap drops and flags
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         ovf_q <= 1'b0;
      else if (run && xferRead_q && !fifoInReady)
         ovf_q <= 1'b1;
   end
   assign tapOverflow = ovf_q;
endmodule // sbs_sram_control

//--- rtl/sbs_regs.vh
// Purpose: constants for the synchronous burst memory control block
// Assumes: 17-bit word address, 36-bit words in four 9-bit lanes
// Notes: included by bare name
// Operation
// - select with load captures address and direction
// - advance high steps counter, uses internal address
// - burst keeps the direction latched at load
// - deselect with load low stops burst
// - bus floats after deselect and through no-ops
// - selected only when all three selects true
// - clock gate high makes edge not happen
// - suspended registers and pins hold
// - outputs float after power-up until operation
// - each lane enable gates nine bits
// - all low writes word, reads ignore enables
// - any lane combination writes each selected lane
// - interleaved order xors count into low bits
// - counter wraps after fourth word, continues
// - order select high interleaved, low linear
// - linear order increments low bits modulo four
// - write data registered, read data flow-through
// - output enable high floats data pins
`ifndef SBS_REGS_VH
`define SBS_REGS_VH
`define SBS_ADDR_W 17
`define SBS_DATA_W 36
`define SBS_LANE_W 9
`define SBS_LANES 4
`define SBS_DEPTH 131072
`define SBS_FIFO_DEPTH 4
`define SBS_FIFO_AW 2
`endif

//--- rtl/sbs_fifo.v
// Purpose: small flip-flop FIFO on the read data path
// Assumes: single clock, asynchronous active-low reset
// Notes: full and empty come from a count, so both are exact
`timescale 1ns/1ps
module sbs_fifo #(
   parameter WIDTH = 36,
   parameter DEPTH = 4,
   parameter AW = 2
)
(
   // clock and reset
   input wire clock,
   input wire arst_n,
   // fill side
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   // drain side
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr_q;
   reg [AW-1:0] rdPtr_q;
   reg [AW:0] count_q;
   wire push;
   wire pop;
   integer i;

   assign inReady = (count_q != DEPTH[AW:0]);
   assign outValid = (count_q != {(AW+1){1'b0}});
   assign outData = mem[rdPtr_q];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wrPtr_q <= {AW{1'b0}};
         rdPtr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1)
            mem[i] <= {WIDTH{1'b0}};
      end
      else
      begin
         if (push)
         begin
            mem[wrPtr_q] <= inData;
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (pop)
            rdPtr_q <= rdPtr_q + 1'b1;
         if (push && !pop)
            count_q <= count_q + 1'b1;
         else if (pop && !push)
            count_q <= count_q - 1'b1;
      end
   end
endmodule // sbs_fifo

//--- tb/sbs_host_model.sv
// Purpose: memory controller model driving the pins of the control block
// Assumes: one call of cyc per clock, pins change just after the edge
// Notes: when no lane is enabled, all data lines show the inverse of their last value
`timescale 1ns/1ps
module sbs_host_model
(
   // clock
   input logic clock,
   // control pins
   output logic clockGate_n,
   output logic advanceOrLoad,
   output logic readNotWrite,
   output logic chipSelectLowA_n,
   output logic chipSelectLowB_n,
   output logic chipSelectHigh,
   output logic [3:0] byteLaneWrite_n,
   output logic [16:0] wordAddress,
   // write data pins
   output logic [31:0] dataIn,
   output logic [3:0] parityLanesIn
);
   // cs: 0 selected, 1 or 2 a low select false, 3 the high select false
   task drive(input logic g, adv, rw, input logic [1:0] cs,
      input logic [16:0] a, input logic [3:0] ln, input logic [35:0] d);
      clockGate_n <= g;
      advanceOrLoad <= adv;
      readNotWrite <= rw;
      chipSelectLowA_n <= cs == 2'h1;
      chipSelectLowB_n <= cs == 2'h2;
      chipSelectHigh <= cs != 2'h3;
      wordAddress <= a;
      // lane enables valid in every command cycle of a write
      byteLaneWrite_n <= ln;
      // no lane wanted: lines are not held, so they toggle
      {parityLanesIn, dataIn} <= ln == 4'hf ? ~{parityLanesIn, dataIn} : d;
   endtask

   task cyc(input logic g, adv, rw, input logic [1:0] cs,
      input logic [16:0] a, input logic [3:0] ln, input logic [35:0] d);
      @(posedge clock);
      drive(g, adv, rw, cs, a, ln, d);
   endtask

   initial
   begin
      {parityLanesIn, dataIn} = 36'h0_0000_0000;
      drive(1'b0, 1'b1, 1'b1, 2'h3, 17'h0_0000, 4'hf, 36'h0_0000_0000);
   end
endmodule // sbs_host_model

//--- tb/sbs_sram_control_monitor.sv
// Purpose: port assertions for the burst memory control block
// Assumes: pins act two edges after sampling, data one cycle later
// Notes: bound to the control block by the bind below
`timescale 1ns/1ps
module sbs_sram_control_monitor
(
   // clock and reset
   input logic clock,
   input logic arst_n,
   // pins
   input logic clockGate_n,
   input logic advanceOrLoad,
   input logic readNotWrite,
   input logic chipSelectLowA_n,
   input logic chipSelectLowB_n,
   input logic chipSelectHigh,
   input logic outputEnable_n,
   input logic [31:0] dataOut,
   input logic [3:0] parityLanesOut,
   input logic dataOe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire sel = !chipSelectLowA_n && !chipSelectLowB_n && chipSelectHigh;
   wire go = !clockGate_n;
   wire ldRd = go && !advanceOrLoad && sel && readNotWrite;
   wire ldWr = go && !advanceOrLoad && sel && !readNotWrite;
   wire desel = go && !advanceOrLoad && !sel;

   oe_float_a: assert property (outputEnable_n |-> !dataOe)
      else $error("data driven with output enable high");
   read_answer_a: assert property (ldRd ##3 !outputEnable_n |-> dataOe)
      else $error("no read data after load read");
   write_float_a: assert property (ldWr ##1 go [*3] |-> !dataOe)
      else $error("data driven in write data phase");
   desel_float_a: assert property (desel ##1 go [*3] |-> !dataOe)
      else $error("bus driven after deselect");
   noop_float_a: assert property (
      desel ##1 (go && advanceOrLoad) [*4] |=> !dataOe)
      else $error("bus driven during no-op");
   burst_read_a: assert property (
      ldRd ##1 (go && advanceOrLoad) [*4] ##1 !outputEnable_n |-> dataOe)
      else $error("burst read word missing");
   suspend_hold_a: assert property (
      clockGate_n |-> ##3 ($stable(dataOut) && $stable(parityLanesOut)))
      else $error("read data changed on suspended edge");
   powerup_float_a: assert property ($rose(arst_n) |-> !dataOe)
      else $error("bus driven at power-up");
endmodule // sbs_sram_control_monitor

bind sbs_sram_control sbs_sram_control_monitor i_mon (.clock(clock),
   .arst_n(arst_n), .clockGate_n(clockGate_n),
   .advanceOrLoad(advanceOrLoad), .readNotWrite(readNotWrite),
   .chipSelectLowA_n(chipSelectLowA_n), .chipSelectLowB_n(chipSelectLowB_n),
   .chipSelectHigh(chipSelectHigh), .outputEnable_n(outputEnable_n),
   .dataOut(dataOut), .parityLanesOut(parityLanesOut), .dataOe(dataOe));

//--- tb/sbs_sram_control_bench.sv
// Purpose: self-checking bench for the burst memory control block
// Assumes: shadow array holds what each write should leave in memory
// Notes: read words are logged once per change while the bus is driven
`timescale 1ns/1ps
module sbs_sram_control_bench;
   logic clock, arst_n, outputEnable_n, burstOrderSelect, tapReady;
   logic clockGate_n, advanceOrLoad, readNotWrite, chipSelectHigh;
   logic chipSelectLowA_n, chipSelectLowB_n, dataOe, tapValid, tapOverflow;
   logic [3:0] byteLaneWrite_n, parityLanesIn, parityLanesOut;
   logic [16:0] wordAddress;
   logic [31:0] dataIn, dataOut;
   logic [35:0] tapData, log[$], mem[int], tapExp[4];
   logic [3:0] masks[7] = '{4'h0, 4'he, 4'hd, 4'hb, 4'h7, 4'ha, 4'hf};
   int bad_count = 0, samples_checked = 0;

   sbs_sram_control i_dut (.clock(clock), .arst_n(arst_n),
      .clockGate_n(clockGate_n), .advanceOrLoad(advanceOrLoad),
      .readNotWrite(readNotWrite), .chipSelectLowA_n(chipSelectLowA_n),
      .chipSelectLowB_n(chipSelectLowB_n), .chipSelectHigh(chipSelectHigh),
      .outputEnable_n(outputEnable_n), .burstOrderSelect(burstOrderSelect),
      .byteLaneWrite_n(byteLaneWrite_n), .wordAddress(wordAddress),
      .dataIn(dataIn), .parityLanesIn(parityLanesIn), .dataOut(dataOut),
      .parityLanesOut(parityLanesOut), .dataOe(dataOe), .tapValid(tapValid),
      .tapReady(tapReady), .tapData(tapData), .tapOverflow(tapOverflow));
   sbs_host_model i_host (.clock(clock), .clockGate_n(clockGate_n),
      .advanceOrLoad(advanceOrLoad), .readNotWrite(readNotWrite),
      .chipSelectLowA_n(chipSelectLowA_n),
      .chipSelectLowB_n(chipSelectLowB_n), .chipSelectHigh(chipSelectHigh),
      .byteLaneWrite_n(byteLaneWrite_n), .wordAddress(wordAddress),
      .dataIn(dataIn), .parityLanesIn(parityLanesIn));

   always #2.5 clock = ~clock;
   // suspended edges repeat a word, so only changes are logged
   always @(negedge clock)
      if (dataOe === 1'b1 && (log.size() == 0 ||
         log[$] !== {parityLanesOut, dataOut}))
         log.push_back({parityLanesOut, dataOut});

   function logic [1:0] nx(input logic [1:0] s, k, input logic il);
      nx = il ? s ^ k : s + k;
   endfunction

   task chk(input string nm, input logic [35:0] e, g);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task wrb(input logic [16:0] a, input logic il);
      logic [16:0] w;
      burstOrderSelect <= il;
      i_host.cyc(0, 1, 1, 2'h3, 0, 4'hf, 0);
      // lanes go with each command cycle, load included
      i_host.cyc(0, 0, 0, 2'h0, a, 4'h0, 0);
      for (int k = 0; k < 4; k++)
      begin
         w = {a[16:2], nx(a[1:0], k[1:0], il)};
         mem[w] = 36'h9_3C3C_0000 ^ {il, w, k[1:0]};
         // last word rides on a deselect and must still land
         i_host.cyc(0, k < 3, 1, k < 3 ? 2'h0 : 2'h3, 0, 4'h0, mem[w]);
      end
   endtask

   task rdb(input logic [16:0] a, input logic il, input int n, s,
      input logic [1:0] dc);
      burstOrderSelect <= il;
      i_host.cyc(0, 1, 1, 2'h3, 0, 4'hf, 0);
      log.delete();
      i_host.cyc(0, 0, 1, 2'h0, a, 4'h0, 0);
      for (int k = 1; k < n; k++)
      begin
         repeat (k == 2 ? s : 0) i_host.cyc(1, 0, 0, 2'h3, 0, 4'h0, 0);
         i_host.cyc(0, 1, 0, 2'h0, 0, 4'h0, 0);
      end
      i_host.cyc(0, 0, 0, dc, 0, 4'h0, 0);
      repeat (6) i_host.cyc(0, 1, 1, 2'h0, 0, 4'hf, 0);
      chk("count", outputEnable_n ? 0 : 36'(n), 36'(log.size()));
      for (int k = 0; k < n && !outputEnable_n; k++)
         chk("word", mem[{a[16:2], nx(a[1:0], k[1:0], il)}], log[k]);
   endtask

   task wl(input logic [16:0] a, input logic [3:0] m, input logic [35:0] d);
      logic [35:0] e;
      e = mem[a];
      for (int i = 0; i < 4; i++)
         if (!m[i])
            {e[32+i], e[8*i+:8]} = {d[32+i], d[8*i+:8]};
      mem[a] = e;
      i_host.cyc(0, 1, 1, 2'h3, 0, 4'hf, 0);
      i_host.cyc(0, 0, 0, 2'h0, a, m, 0);
      i_host.cyc(0, 0, 0, 2'h3, 0, m, d);
   endtask

   task complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      #200000;
      bad_count++;
      complete_run;
   end

   initial
   begin
      clock = 0;
      arst_n = 0;
      outputEnable_n = 0;
      burstOrderSelect = 0;
      tapReady = 0;
      repeat (6) @(posedge clock);
      arst_n <= 1;
      @(negedge clock);
      chk("dataOe", 0, dataOe);
      for (int il = 0; il < 2; il++)
         for (int st = 0; st < 4; st++)
         begin
            wrb({15'h1234, st[1:0]}, il[0]);
            rdb({15'h1234, 2'h0}, 1'b0, 5, 0, 2'h3);
            for (int j = 0; j < 4 && il + st == 0; j++)
               tapExp[j] = mem[{15'h1234, j[1:0]}];
         end
      rdb({15'h1234, 2'h2}, 1'b1, 8, 3, 2'h3);
      for (int dc = 1; dc < 4; dc++)
         rdb({15'h1234, 2'h1}, 1'b0, 1, 0, dc[1:0]);
      for (int j = 0; j < 7; j++)
      begin
         wl(17'h0_2220, masks[j], {9{j[3:0] + 4'h1}});
         rdb(17'h0_2220, 1'b0, 1, 0, 2'h3);
      end
      outputEnable_n <= 1;
      rdb({15'h1234, 2'h0}, 1'b0, 4, 0, 2'h3);
      outputEnable_n <= 0;
      // tap was never drained, so only the first four read words survive
      chk("tapOverflow", 1, tapOverflow);
      tapReady <= 1;
      for (int j = 0; j < 4; j++)
      begin
         @(negedge clock);
         chk("tapData", tapExp[j], tapValid ? tapData : 'x);
         @(posedge clock);
      end
      @(negedge clock);
      chk("tapValid", 0, tapValid);
      complete_run;
   end
endmodule // sbs_sram_control_bench
